// ---- core/rolling_shutter_readout_seq.sv ----
// Sensor-side readout sequencer: column scan, converter, row pointers,
// gain and offset selection. Assumes controller drives pins at <= 10 MHz.
// Functional notes
// (RULE1) Controller drives column and converter from one clock
// (RULE2) Column clock fall selects next pixel
// (RULE3) Converter freezes input on its clock fall
// (RULE4) Digital word lags analog by one pixel
// (RULE5) End-of-scan low for one column period
// (RULE6) Black level output after end-of-scan until sync
// (RULE7) Controller pulses fast calibration once per frame
// (RULE8) Controller drives unity gain like fast calibration
// (RULE9) Controller adds one reset pass per frame
// (RULE10) Row clock advances both row pointers together
// (RULE11) Pointer select picks left or right pointer
// (RULE12) Controller sets exposure by sync spacing
// (RULE13) Shutter off keeps pointer select low
// (RULE14) Controller keeps row clock running always; the bench toggles it only inside row_step
// (RULE15) Each pointer synced once per frame
// (RULE16) Four-bit word selects amplifier gain
// (RULE17) Four-bit word selects one of sixteen offset taps
// (RULE18) Controller picks lowest sufficient gain for dual slope
// (RULE19) Syncs asserted only while their clock high
// (RULE20) First dummy pixel after third column clock fall
// (RULE21) Controller holds gain and offset stable during readout
`timescale 1ns/1ps
module rolling_shutter_readout_seq
  import readout_pkg::*;
#(
  parameter int NUM_COLS = readout_pkg::DEF_COLS,
  parameter int NUM_ROWS = readout_pkg::DEF_ROWS
) (
  input  wire logic                             I_REF_CLK,
  input  wire logic                             I_ARST_N,
  input  wire logic                             I_COL_CLK,
  input  wire logic                             I_ADC_CLK,
  input  wire logic                             I_ROW_CLK,
  input  wire logic                             I_COL_SYNC_N,
  input  wire logic                             I_LEFT_ROW_POINTER_SYNC_N,
  input  wire logic                             I_RIGHT_ROW_POINTER_SYNC_N,
  input  wire logic                             I_POINTER_SELECT,
  input  wire logic                             I_ROW_SELECT,
  input  wire logic                             I_ROW_RESET,
  input  wire logic [readout_pkg::CODE_W-1:0]   I_GAIN_WORD,
  input  wire logic [readout_pkg::CODE_W-1:0]   I_OFFSET_WORD,
  input  wire logic [readout_pkg::PIX_W-1:0]    I_PIXEL_LEVEL,
  output logic      [readout_pkg::COL_W-1:0]    O_COL_ADDR,
  output logic                                  O_COL_ACTIVE,
  output logic      [readout_pkg::PIX_W-1:0]    O_ANALOG_LEVEL,
  output logic                                  O_BLACK_REF,
  output logic                                  O_COL_EOS_N,
  output logic      [readout_pkg::PIX_W-1:0]    O_PIXEL_WORD,
  output logic                                  O_PIXEL_STROBE,
  output readout_pkg::row_ptr_type              O_LEFT_ROW_PTR,
  output readout_pkg::row_ptr_type              O_RIGHT_ROW_PTR,
  output logic      [readout_pkg::ROW_W-1:0]    O_ROW_ADDR,
  output logic                                  O_ROW_SELECT,
  output logic                                  O_ROW_RESET,
  output logic      [readout_pkg::CODE_W-1:0]   O_GAIN_CODE,
  output logic      [readout_pkg::TAPS-1:0]     O_OFFSET_TAP
);
  import readout_pkg::*;

  localparam logic [COL_W-1:0] LAST_COL = COL_W'(NUM_COLS - 1);
  localparam logic [ROW_W-1:0] LAST_ROW = ROW_W'(NUM_ROWS - 1);

  if (NUM_COLS < 2 || NUM_COLS > (1 << COL_W)) begin : g_bad_cols
    $error("NUM_COLS out of range");
  end
  if (NUM_ROWS < 2 || NUM_ROWS > (1 << ROW_W)) begin : g_bad_rows
    $error("NUM_ROWS out of range");
  end

  pins_type pins_raw;
  pins_type pins;
  pins_type pins_p_q;

  assign pins_raw = '{col_clk:      I_COL_CLK,
                      adc_clk:      I_ADC_CLK,
                      row_clk:      I_ROW_CLK,
                      col_sync_n:   I_COL_SYNC_N,
                      left_sync_n:  I_LEFT_ROW_POINTER_SYNC_N,
                      right_sync_n: I_RIGHT_ROW_POINTER_SYNC_N,
                      ptr_sel:      I_POINTER_SELECT,
                      row_sel:      I_ROW_SELECT,
                      row_rst:      I_ROW_RESET,
                      gain:         I_GAIN_WORD,
                      offset:       I_OFFSET_WORD};

  pin_sync #(
    .WIDTH (SYNC_W)
  ) u_pin_sync (
    .i_clk    (I_REF_CLK),
    .i_arst_n (I_ARST_N),
    .i_async  (pins_raw),
    .o_sync   (pins)
  );

  // Previous synced values for edge detection
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pins_p_q <= '0;
    end else begin
      pins_p_q <= pins;
    end
  end

  logic col_fall;
  logic adc_fall;
  logic row_fall;
  logic col_sync;

  assign col_fall = pins_p_q.col_clk & ~pins.col_clk;
  assign adc_fall = pins_p_q.adc_clk & ~pins.adc_clk;
  assign row_fall = pins_p_q.row_clk & ~pins.row_clk;
  assign col_sync = ~pins.col_sync_n & pins.col_clk; // RULE19

  // Column scan
  col_state_type    col_state_q;
  logic [1:0]       skip_q;
  logic [COL_W-1:0] col_q;

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      col_state_q <= COL_IDLE;
      skip_q      <= 2'h0;
      col_q       <= '0;
    end else if (col_sync) begin
      col_state_q <= COL_SKIP;
      skip_q      <= 2'h0;
      col_q       <= '0;
    end else if (col_fall) begin
      case (col_state_q)
        COL_SKIP: begin
          if (skip_q == SKIP_EDGES) begin
            col_state_q <= COL_SCAN; // RULE20
            col_q       <= '0;
          end else begin
            skip_q <= skip_q + 2'h1;
          end
        end
        COL_SCAN: begin
          if (col_q == LAST_COL) begin
            col_state_q <= COL_EOS; // RULE5
          end else begin
            col_q <= col_q + 1'b1; // RULE2
          end
        end
        COL_EOS: begin
          col_state_q <= COL_BLACK; // RULE6
        end
        default: begin
          col_state_q <= col_state_q;
        end
      endcase
    end
  end

  logic black;

  assign black = (col_state_q != COL_SCAN); // RULE6

  // Pixel routed to the amplifier, black level outside the scan
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_COL_ADDR     <= '0;
      O_COL_ACTIVE   <= 1'b0;
      O_ANALOG_LEVEL <= BLACK_LEVEL;
      O_BLACK_REF    <= 1'b1;
      O_COL_EOS_N    <= 1'b1;
    end else begin
      O_COL_ADDR     <= col_q; // RULE2
      O_COL_ACTIVE   <= ~black;
      O_ANALOG_LEVEL <= black ? BLACK_LEVEL : I_PIXEL_LEVEL;
      O_BLACK_REF    <= black;
      O_COL_EOS_N    <= (col_state_q != COL_EOS); // RULE5
    end
  end

  // Converter: level settles two cycles after selection, so the
  // capture waits one cycle past the fall to hold the previous pixel
  logic adc_fall_q;

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      adc_fall_q     <= 1'b0;
      O_PIXEL_WORD   <= '0;
      O_PIXEL_STROBE <= 1'b0;
    end else begin
      adc_fall_q     <= adc_fall; // RULE3
      O_PIXEL_STROBE <= adc_fall_q;
      if (adc_fall_q) begin
        O_PIXEL_WORD <= O_ANALOG_LEVEL; // RULE4
      end
    end
  end

  // Row pointers, index 0 left and 1 right
  logic [1:0]             rsync;
  logic [1:0][ROW_W-1:0]  row_q;
  logic [1:0][1:0]        rskip_q;
  logic [1:0]             rvalid_q;
  logic [1:0]             reos_q;
  row_ptr_type [1:0]      ptr;

  assign rsync[0] = ~pins.left_sync_n & pins.row_clk;  // RULE19
  assign rsync[1] = ~pins.right_sync_n & pins.row_clk; // RULE19

  for (genvar p = 0; p < 2; p++) begin : g_ptr
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
        row_q[p]    <= '0;
        rskip_q[p]  <= 2'h0;
        rvalid_q[p] <= 1'b0;
        reos_q[p]   <= 1'b0;
      end else if (rsync[p]) begin
        row_q[p]    <= '0;
        rskip_q[p]  <= 2'h0;
        rvalid_q[p] <= 1'b0;
        reos_q[p]   <= 1'b0;
      end else if (row_fall) begin // RULE10
        reos_q[p] <= 1'b0;
        if (!rvalid_q[p] && !reos_q[p] && rskip_q[p] != 2'h3) begin
          if (rskip_q[p] == SKIP_EDGES) begin
            rvalid_q[p] <= 1'b1;
            rskip_q[p]  <= 2'h3;
          end else begin
            rskip_q[p] <= rskip_q[p] + 2'h1;
          end
        end else if (rvalid_q[p]) begin
          if (row_q[p] == LAST_ROW) begin
            rvalid_q[p] <= 1'b0;
            reos_q[p]   <= 1'b1;
          end else begin
            row_q[p] <= row_q[p] + 1'b1; // RULE10
          end
        end
      end
    end
    assign ptr[p] = '{valid: rvalid_q[p], eos_n: ~reos_q[p], row: row_q[p]};
  end

  // Pointer select steers row select and row reset
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_LEFT_ROW_PTR  <= '{valid: 1'b0, eos_n: 1'b1, row: '0};
      O_RIGHT_ROW_PTR <= '{valid: 1'b0, eos_n: 1'b1, row: '0};
      O_ROW_ADDR      <= '0;
      O_ROW_SELECT    <= 1'b0;
      O_ROW_RESET     <= 1'b0;
    end else begin
      O_LEFT_ROW_PTR  <= ptr[0];
      O_RIGHT_ROW_PTR <= ptr[1];
      if (pins.ptr_sel) begin // RULE11
        O_ROW_ADDR   <= ptr[0].row;
        O_ROW_SELECT <= pins.row_sel & ptr[0].valid;
        O_ROW_RESET  <= pins.row_rst & ptr[0].valid;
      end else begin
        O_ROW_ADDR   <= ptr[1].row;
        O_ROW_SELECT <= pins.row_sel & ptr[1].valid;
        O_ROW_RESET  <= pins.row_rst & ptr[1].valid;
      end
    end
  end

  // Gain code and one-hot offset tap
  logic [TAPS-1:0] tap;

  for (genvar t = 0; t < TAPS; t++) begin : g_tap
    assign tap[t] = (pins.offset == CODE_W'(t)); // RULE17
  end

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_GAIN_CODE  <= '0;
      O_OFFSET_TAP <= TAPS'(1);
    end else begin
      O_GAIN_CODE  <= pins.gain; // RULE16
      O_OFFSET_TAP <= tap;       // RULE17
    end
  end

endmodule : rolling_shutter_readout_seq

// ---- core/readout_pkg.sv ----
// Shared constants and carrier types for the sensor readout sequencer.
// Assumes all controller pins arrive asynchronous to the reference clock.
package readout_pkg;

  localparam int          COL_W        = 11;
  localparam int          ROW_W        = 11;
  localparam int          PIX_W        = 10;
  localparam int          CODE_W       = 4;
  localparam int          TAPS         = 16;
  localparam int          DEF_COLS     = 1286;
  localparam int          DEF_ROWS     = 1030;
  localparam logic [1:0]  SKIP_EDGES   = 2'h2;
  localparam logic [9:0]  BLACK_LEVEL  = 10'h040;
  localparam int          SYNC_W       = 17;

  // Pin bundle, in synchroniser order
  typedef struct packed {
    logic              col_clk;
    logic              adc_clk;
    logic              row_clk;
    logic              col_sync_n;
    logic              left_sync_n;
    logic              right_sync_n;
    logic              ptr_sel;
    logic              row_sel;
    logic              row_rst;
    logic [CODE_W-1:0] gain;
    logic [CODE_W-1:0] offset;
  } pins_type;

  typedef struct packed {
    logic             valid;
    logic             eos_n;
    logic [ROW_W-1:0] row;
  } row_ptr_type;

  typedef enum logic [4:0] {
    COL_IDLE  = 5'h01,
    COL_SKIP  = 5'h02,
    COL_SCAN  = 5'h04,
    COL_EOS   = 5'h08,
    COL_BLACK = 5'h10
  } col_state_type;

endpackage : readout_pkg

// ---- core/pin_sync.sv ----
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level or a clock well below half the rate.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : pin_sync

// ---- verification/readout_chk.sv ----
// Port checker for the readout sequencer.
// Assumes a 10 MHz column clock and gain/offset held in reset.
`timescale 1ns/1ps
module readout_chk
  import readout_pkg::*;
(
  input  wire logic              I_REF_CLK,
  input  wire logic              I_ARST_N,
  input  wire logic [CODE_W-1:0] I_GAIN_WORD,
  input  wire logic [CODE_W-1:0] I_OFFSET_WORD,
  input  wire logic [COL_W-1:0]  O_COL_ADDR,
  input  wire logic              O_COL_ACTIVE,
  input  wire logic [PIX_W-1:0]  O_ANALOG_LEVEL,
  input  wire logic              O_BLACK_REF,
  input  wire logic              O_COL_EOS_N,
  input  wire logic              O_PIXEL_STROBE,
  input  wire row_ptr_type       O_LEFT_ROW_PTR,
  input  wire row_ptr_type       O_RIGHT_ROW_PTR,
  input  wire logic [CODE_W-1:0] O_GAIN_CODE,
  input  wire logic [TAPS-1:0]   O_OFFSET_TAP
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_ARST_N);
  a_black_level: assert property (O_BLACK_REF |->
    O_ANALOG_LEVEL == BLACK_LEVEL) else $error("black level wrong");
  a_eos_short: assert property ($fell(O_COL_EOS_N) |->
    ##[1:8] O_COL_EOS_N) else $error("end of scan too long");
  a_eos_then_black: assert property ($rose(O_COL_EOS_N) |->
    O_BLACK_REF && !O_COL_ACTIVE) else $error("no black after scan");
  a_col_step: assert property (O_COL_ACTIVE && $past(O_COL_ACTIVE) &&
    O_COL_ADDR != $past(O_COL_ADDR) |-> O_COL_ADDR == $past(O_COL_ADDR) + 1'b1)
    else $error("column skipped");
  a_strobe_pulse: assert property (O_PIXEL_STROBE |=>
    !O_PIXEL_STROBE) else $error("strobe too long");
  a_gain_follow: assert property ($past(I_ARST_N, 3) |->
    O_GAIN_CODE == $past(I_GAIN_WORD, 3)) else $error("gain code wrong");
  a_offset_follow: assert property ($past(I_ARST_N, 3) |->
    O_OFFSET_TAP == 16'h0001 << $past(I_OFFSET_WORD, 3))
    else $error("offset tap wrong");
  a_ptr_together: assert property ($changed(O_LEFT_ROW_PTR.row) &&
    O_LEFT_ROW_PTR.valid && $past(O_LEFT_ROW_PTR.valid) &&
    O_RIGHT_ROW_PTR.valid && $past(O_RIGHT_ROW_PTR.valid) |->
    $changed(O_RIGHT_ROW_PTR.row)) else $error("pointers split");
endmodule : readout_chk
bind rolling_shutter_readout_seq readout_chk u_chk (.*);

// ---- verification/ctl_model.sv ----
// Controller model: one clock for column and converter, pixel array.
// Assumes the bench reference clock and a run request.
`timescale 1ns/1ps
module ctl_model
  import readout_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_run,
  input  wire logic [COL_W-1:0] i_col,
  output logic                  o_clk,
  output logic      [PIX_W-1:0] o_pix
);
  initial o_clk = 1'b1;
  // Clock stands high outside readout
  always @(posedge i_clk) begin
    o_clk <= i_run ? ~o_clk : 1'b1;
  end
  // Pixel value marks its column
  assign o_pix = 10'h100 + PIX_W'(i_col);
endmodule : ctl_model

// ---- verification/testbench.sv ----
// Self-checking bench for the readout sequencer.
// Assumes four columns, four rows and the controller model.
`timescale 1ns/1ps
module testbench;
  import readout_pkg::*;
  logic I_REF_CLK = 1'b0, I_ARST_N = 1'b0, I_COL_CLK, I_ADC_CLK, run = 1'b0;
  logic I_ROW_CLK = 1'b1, I_COL_SYNC_N = 1'b1, I_POINTER_SELECT = 1'b0;
  logic I_LEFT_ROW_POINTER_SYNC_N = 1'b1, I_RIGHT_ROW_POINTER_SYNC_N = 1'b1;
  logic I_ROW_SELECT = 1'b0, I_ROW_RESET = 1'b0, O_COL_ACTIVE, O_BLACK_REF;
  logic O_COL_EOS_N, O_PIXEL_STROBE, O_ROW_SELECT, O_ROW_RESET;
  logic [CODE_W-1:0] I_GAIN_WORD = 4'h0, I_OFFSET_WORD = 4'h0, O_GAIN_CODE;
  logic [PIX_W-1:0]  I_PIXEL_LEVEL, O_ANALOG_LEVEL, O_PIXEL_WORD;
  logic [COL_W-1:0]  O_COL_ADDR;
  logic [ROW_W-1:0]  O_ROW_ADDR;
  logic [TAPS-1:0]   O_OFFSET_TAP;
  row_ptr_type       O_LEFT_ROW_PTR, O_RIGHT_ROW_PTR;
  logic [PIX_W-1:0]  words[$];
  logic fast_cal = 1'b0, unity_gain;
  int n_errors = 0, total_checks = 0, cyc = 0, eos_cyc = 0, n_cal = 0;
  always #25 I_REF_CLK = ~I_REF_CLK;
  assign I_ADC_CLK = I_COL_CLK;
  assign unity_gain = fast_cal;
  rolling_shutter_readout_seq #(.NUM_COLS(4), .NUM_ROWS(4)) dut (.*);
  ctl_model model (.i_clk(I_REF_CLK), .i_run(run), .i_col(O_COL_ADDR),
    .o_clk(I_COL_CLK), .o_pix(I_PIXEL_LEVEL));
  task automatic tick(input int n);
    repeat (n) @(negedge I_REF_CLK);
  endtask : tick
  task automatic chk(input string s, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", s, e, g);
      n_errors++;
    end
  endtask : chk
  task automatic row_step(input logic l, input logic r);
    I_ROW_CLK = 1'b1;
    fast_cal = l;
    tick(2);
    I_LEFT_ROW_POINTER_SYNC_N = ~l;
    I_RIGHT_ROW_POINTER_SYNC_N = ~r;
    tick(3);
    I_LEFT_ROW_POINTER_SYNC_N = 1'b1;
    I_RIGHT_ROW_POINTER_SYNC_N = 1'b1;
    tick(2);
    n_cal += int'(unity_gain);
    fast_cal = 1'b0;
    I_ROW_CLK = 1'b0;
    tick(5);
  endtask : row_step
  task automatic tally_and_finish();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  always @(negedge I_REF_CLK) begin
    cyc++;
    if (O_PIXEL_STROBE === 1'b1 && O_PIXEL_WORD !== BLACK_LEVEL) begin
      words.push_back(O_PIXEL_WORD);
    end
    if (O_COL_EOS_N === 1'b0) begin
      eos_cyc++;
    end
    if (cyc == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    tick(1);
    chk("rst_level", BLACK_LEVEL, O_ANALOG_LEVEL);
    chk("rst_tap", 16'h1, O_OFFSET_TAP);
    chk("rst_eos", 16'h1, O_COL_EOS_N);
    tick(1);
    I_ARST_N = 1'b1;
    for (int v = 0; v < 16; v++) begin
      I_GAIN_WORD = 4'(v);
      I_OFFSET_WORD = 4'(15 - v);
      tick(4);
      chk("gain", 16'(v), O_GAIN_CODE);
      chk("tap", 16'h1 << (15 - v), O_OFFSET_TAP);
    end
    I_GAIN_WORD = 4'h0;
    tick(4);
    chk("gain_low", 16'h0, O_GAIN_CODE);
    I_COL_SYNC_N = 1'b0;
    tick(3);
    I_COL_SYNC_N = 1'b1;
    tick(3);
    run = 1'b1;
    tick(30);
    run = 1'b0;
    tick(4);
    chk("n_words", 16'h4, 16'(words.size()));
    for (int i = 0; i < 4; i++) begin
      chk("word", 16'h100 + 16'(i), words[i]);
    end
    chk("eos_len", 16'h2, 16'(eos_cyc));
    chk("black", 16'h1, O_BLACK_REF);
    chk("level", BLACK_LEVEL, O_ANALOG_LEVEL);
    I_ROW_SELECT = 1'b1;
    I_ROW_RESET = 1'b1;
    I_POINTER_SELECT = 1'b0;
    row_step(1'b1, 1'b0);
    row_step(1'b0, 1'b0);
    row_step(1'b0, 1'b1);
    row_step(1'b0, 1'b0);
    row_step(1'b0, 1'b0);
    chk("left", 16'h2, O_LEFT_ROW_PTR.row);
    chk("right", 16'h0, O_RIGHT_ROW_PTR.row);
    row_step(1'b0, 1'b0);
    I_POINTER_SELECT = 1'b1;
    tick(5);
    chk("addr_l", 16'h3, O_ROW_ADDR);
    I_POINTER_SELECT = 1'b0;
    tick(5);
    chk("addr_r", 16'h1, O_ROW_ADDR);
    chk("sel_r", 16'h1, O_ROW_SELECT);
    row_step(1'b0, 1'b0);
    I_POINTER_SELECT = 1'b1;
    tick(5);
    chk("left_end", 16'h0, {O_LEFT_ROW_PTR.valid, O_LEFT_ROW_PTR.eos_n});
    chk("rst_l", 16'h0, O_ROW_RESET);
    chk("right_end", 16'h2, O_RIGHT_ROW_PTR.row);
    chk("cal_count", 16'h1, 16'(n_cal));
    tally_and_finish();
  end
endmodule : testbench
